//--- rtl/conv_clock_divider.sv
// Purpose: conversion-clock enable pulse generator
// Assumes: select held stable while running
// Notes: pulse every ratio cycles while run is high
`timescale 1ns/1ps
module conv_clock_divider (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [5:0] ratio_in,
  output logic tick_out
);
  logic [5:0] count_r;
  wire logic last_w = (count_r == ratio_in - 6'h01);
  always_ff @(posedge clock_in) begin
    if (rst_in || !run_in) begin
      count_r <= 6'h00;
      tick_out <= 1'b0;
    end else begin
      count_r <= last_w ? 6'h00 : count_r + 6'h01;
      tick_out <= last_w;
    end
  end
endmodule : conv_clock_divider

//--- rtl/conv_timing_consts.svh
// Purpose: offsets, fields, reset values and timing counts
// Assumes: 32-bit apb data, word-aligned registers
// Notes: included by bare name
`ifndef CONV_TIMING_CONSTS_SVH
`define CONV_TIMING_CONSTS_SVH
`define MODE_REG_OFFSET 12'h000
`define CTRL_REG_OFFSET 12'h004
`define STATUS_REG_OFFSET 12'h008
`define MODE_DIV_LSB 0
`define MODE_LV_LSB 3
`define MODE_RES_BIT 5
`define MODE_WAIT_BIT 6
`define CTRL_RUN_BIT 0
`define CTRL_CE_BIT 1
`define CTRL_FIRST_BIT 2
`define MODE_RESET 7'h00
`define CONV_CLK_12B_M0 9'h036
`define CONV_CLK_12B_M1 9'h042
`define CONV_CLK_12B_M2 9'h04c
`define CONV_CLK_12B_M3 9'h0e6
`define CONV_CLK_8B_M0 9'h029
`define CONV_CLK_8B_M1 9'h035
`define CONV_CLK_8B_M2 9'h03f
`define CONV_CLK_8B_M3 9'h0d9
`define SAMP_CLK_M0 9'h00b
`define SAMP_CLK_M1 9'h017
`define SAMP_CLK_M2 9'h021
`define SAMP_CLK_M3 9'h0bb
`define STAB_M0 6'h04
`define STAB_M0_DIV1 6'h02
`define STAB_M1 6'h3a
`define STAB_M1_DIV1 6'h1d
`define STAB_M2 6'h0f
`define STAB_M3 6'h08
`endif

//--- rtl/conv_timing_pkg.sv
// Purpose: types of the conversion-timing selector
// Assumes: nothing
// Notes: constants live in the header
package conv_timing_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_stab,
    st_conv
  } seq_state_t;
endpackage : conv_timing_pkg

//--- rtl/conv_timing_select.sv
// Purpose: apb-configured a/d conversion timing sequencer
// Assumes: apb master obeys protocol; triggers synchronous
// Notes: zero-wait apb slave, pslverr on unmapped address
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "conv_timing_consts.svh"
module conv_timing_select (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic hw_trigger_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic busy_out,
  output logic sampling_out,
  output logic conv_done_out,
  output logic conv_tick_out
);
  function automatic logic [5:0] div_ratio(input logic [2:0] sel);
    case (sel)
      3'h0: div_ratio = 6'h20;
      3'h1: div_ratio = 6'h10;
      3'h2: div_ratio = 6'h08;
      3'h3: div_ratio = 6'h06;
      3'h4: div_ratio = 6'h05;
      3'h5: div_ratio = 6'h04;
      3'h6: div_ratio = 6'h02;
      default: div_ratio = 6'h01;
    endcase
  endfunction : div_ratio

  logic [6:0] mode_r;
  logic run_r;
  logic ce_r;
  logic first_r;
  logic [5:0] stab_cnt_r;
  logic [8:0] conv_cnt_r;
  conv_timing_pkg::seq_state_t state_r;
  logic tick_w;

  wire logic [2:0] div_sel_w = mode_r[`MODE_DIV_LSB +: 3];
  wire logic [1:0] lv_w = mode_r[`MODE_LV_LSB +: 2];
  wire logic res8_w = mode_r[`MODE_RES_BIT];
  wire logic hw_wait_w = mode_r[`MODE_WAIT_BIT];
  wire logic div1_w = (div_sel_w == 3'h7);
  wire logic [5:0] ratio_w = div_ratio(div_sel_w);
  wire logic setup_w = psel_in && !penable_in;
  wire logic acc_w = psel_in && penable_in;
  wire logic wr_w = acc_w && pwrite_in;
  wire logic hit_mode_w = (paddr_in == `MODE_REG_OFFSET);
  wire logic hit_ctrl_w = (paddr_in == `CTRL_REG_OFFSET);
  wire logic hit_stat_w = (paddr_in == `STATUS_REG_OFFSET);
  wire logic mapped_w = hit_mode_w || hit_ctrl_w || hit_stat_w;
  wire logic stopped_w = !run_r && !ce_r;
  wire logic start_hw_w = hw_wait_w && ce_r && hw_trigger_in &&
                          (state_r == conv_timing_pkg::st_idle);
  wire logic start_sw_w = !hw_wait_w && ce_r && run_r &&
                          (state_r == conv_timing_pkg::st_idle);
  // stabilization count per mode, halved cases at divide-by-1
  wire logic [5:0] stab_w =
    (lv_w == 2'h0) ? (div1_w ? `STAB_M0_DIV1 : `STAB_M0) :
    (lv_w == 2'h1) ? (div1_w ? `STAB_M1_DIV1 : `STAB_M1) :
    (lv_w == 2'h2) ? `STAB_M2 : `STAB_M3;
  wire logic [8:0] conv12_w =
    (lv_w == 2'h0) ? `CONV_CLK_12B_M0 :
    (lv_w == 2'h1) ? `CONV_CLK_12B_M1 :
    (lv_w == 2'h2) ? `CONV_CLK_12B_M2 : `CONV_CLK_12B_M3;
  wire logic [8:0] conv8_w =
    (lv_w == 2'h0) ? `CONV_CLK_8B_M0 :
    (lv_w == 2'h1) ? `CONV_CLK_8B_M1 :
    (lv_w == 2'h2) ? `CONV_CLK_8B_M2 : `CONV_CLK_8B_M3;
  wire logic [8:0] conv_w = res8_w ? conv8_w : conv12_w;
  wire logic [8:0] samp_w =
    (lv_w == 2'h0) ? `SAMP_CLK_M0 :
    (lv_w == 2'h1) ? `SAMP_CLK_M1 :
    (lv_w == 2'h2) ? `SAMP_CLK_M2 : `SAMP_CLK_M3;
  // wait only for the first hardware-triggered conversion of a run
  wire logic need_wait_w = hw_wait_w && first_r;
  wire logic conv_last_w = (state_r == conv_timing_pkg::st_conv) &&
                           tick_w && (conv_cnt_r == conv_w - 9'h001);
  wire logic run_clear_w = wr_w && hit_ctrl_w &&
                           !pwdata_in[`CTRL_RUN_BIT];
  wire logic [31:0] rdata_w =
    hit_mode_w ? {25'h0000000, mode_r} :
    hit_ctrl_w ? {29'h00000000, first_r, ce_r, run_r} :
    hit_stat_w ? {21'h000000, samp_w[1:0] == 2'h0, busy_out,
                  conv_cnt_r} : 32'h00000000;

  conv_clock_divider u_div (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .run_in(state_r == conv_timing_pkg::st_conv),
    .ratio_in(ratio_w),
    .tick_out(tick_w)
  );

  // every access is answered in its first access cycle
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else begin
      pready_out <= setup_w;
      pslverr_out <= setup_w && !mapped_w;
      prdata_out <= (setup_w && !pwrite_in) ? rdata_w : 32'h00000000;
    end
  end

  // timing fields are locked while run or enable is set
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      mode_r <= `MODE_RESET;
    end else if (wr_w && hit_mode_w && stopped_w) begin
      mode_r <= pwdata_in[6:0];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ce_r <= 1'b0;
      first_r <= 1'b1;
    end else begin
      if (wr_w && hit_ctrl_w && !run_r) begin
        ce_r <= pwdata_in[`CTRL_CE_BIT];
      end
      if (wr_w && hit_ctrl_w && pwdata_in[`CTRL_FIRST_BIT]) begin
        first_r <= 1'b1;
      end else if (start_hw_w || run_clear_w || !ce_r) begin
        first_r <= start_hw_w ? 1'b0 : 1'b1;
      end
    end
  end

  // trigger wins over a same-cycle software clear
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      run_r <= 1'b0;
    end else if (start_hw_w) begin
      run_r <= 1'b1;
    end else if (run_clear_w) begin
      run_r <= 1'b0;
    end else if (wr_w && hit_ctrl_w && !hw_wait_w && ce_r) begin
      run_r <= pwdata_in[`CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_r <= conv_timing_pkg::st_idle;
      stab_cnt_r <= 6'h00;
      conv_cnt_r <= 9'h000;
    end else begin
      case (state_r)
        conv_timing_pkg::st_idle: begin
          stab_cnt_r <= 6'h00;
          conv_cnt_r <= 9'h000;
          if (start_hw_w && need_wait_w) begin
            state_r <= conv_timing_pkg::st_stab;
          end else if (start_hw_w || start_sw_w) begin
            state_r <= conv_timing_pkg::st_conv;
          end
        end
        conv_timing_pkg::st_stab: begin
          stab_cnt_r <= stab_cnt_r + 6'h01;
          if (stab_cnt_r == stab_w - 6'h01) begin
            state_r <= conv_timing_pkg::st_conv;
          end
        end
        conv_timing_pkg::st_conv: begin
          if (tick_w) begin
            conv_cnt_r <= conv_cnt_r + 9'h001;
          end
          // clearing run abandons the conversion in flight
          if (conv_last_w || !run_r) begin
            state_r <= conv_timing_pkg::st_idle;
          end
        end
        default: state_r <= conv_timing_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      sampling_out <= 1'b0;
      conv_done_out <= 1'b0;
      conv_tick_out <= 1'b0;
    end else begin
      busy_out <= (state_r != conv_timing_pkg::st_idle);
      sampling_out <= (state_r == conv_timing_pkg::st_conv) &&
                      (conv_cnt_r < samp_w);
      conv_done_out <= conv_last_w;
      // at divide-by-1 the divider ticks once more as the state leaves
      // conversion, so ticks are shown only while converting
      conv_tick_out <= tick_w &&
                       (state_r == conv_timing_pkg::st_conv);
    end
  end
endmodule : conv_timing_select

//--- test/conv_timing_properties.sv
// Purpose: port checks of the timing selector
// Assumes: zero-wait apb slave, registered outputs
// Notes: bound to every selector instance
`timescale 1ns/1ps
module conv_timing_properties (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [11:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic busy_out,
  input wire logic sampling_out,
  input wire logic conv_done_out,
  input wire logic conv_tick_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  chk_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("setup not answered");
  chk_ready_once: assert property (pready_out |=> !pready_out)
    else $error("ready held");
  chk_err_unmapped: assert property (psel_in && !penable_in &&
    paddr_in > 12'h008 |=> pslverr_out) else $error("no error");
  chk_err_mapped: assert property (psel_in && !penable_in &&
    paddr_in inside {12'h000, 12'h004, 12'h008} |=> !pslverr_out)
    else $error("false error");
  chk_done_once: assert property (conv_done_out |=> !conv_done_out)
    else $error("done held");
  chk_samp_busy: assert property (sampling_out |-> busy_out)
    else $error("sampling while idle");
  chk_done_unsampled: assert property (conv_done_out |-> !sampling_out)
    else $error("done in sampling");
  chk_no_early_done: assert property ($rose(busy_out) |->
    !conv_done_out [*8]) else $error("done too soon");
  chk_idle_after_done: assert property (conv_done_out |=> !busy_out)
    else $error("busy after done");
endmodule : conv_timing_properties
bind conv_timing_select conv_timing_properties chk (.clock_in, .rst_in,
  .psel_in, .penable_in, .paddr_in, .pready_out, .pslverr_out,
  .busy_out, .sampling_out, .conv_done_out, .conv_tick_out);

//--- test/conv_timing_select_tb_top.sv
// Purpose: self-checking bench of the timing selector
// Assumes: zero-wait apb slave
// Notes: pipeline slack of 6 cycles on durations
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("BAD %s exp %0d got %0d", n, e, g); end end
module conv_timing_select_tb_top;
  logic clock_in = 0, rst_in = 1, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, fire = 0, pready_out, pslverr_out, er;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, rd;
  logic busy_out, sampling_out, conv_done_out, conv_tick_out, trig;
  int n_fail = 0, num_checks = 0, cyc = 0, tk, cy, sp;
  int smp[4] = '{11, 23, 33, 187};
  int n12[4] = '{54, 66, 76, 230};
  int n8[4] = '{41, 53, 63, 217};
  int stb[4] = '{4, 58, 15, 8};
  int rat[8] = '{32, 16, 8, 6, 5, 4, 2, 1};
  conv_timing_select uut (.clock_in, .rst_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .hw_trigger_in(trig),
    .prdata_out, .pready_out, .pslverr_out, .busy_out, .sampling_out,
    .conv_done_out, .conv_tick_out);
  trig_source src (.clock_in, .rst_in, .fire_in(fire),
    .hw_trigger_out(trig));
  initial forever #2.5 clock_in = ~clock_in;
  task automatic end_of_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // limit is well above the whole bench run, about 6500 cycles
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic xf(input logic w, input logic [11:0] a, input int d);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in) penable_in <= 1;
    do @(posedge clock_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    // one idle edge, so psel is never driven twice in one step
    @(posedge clock_in);
  endtask : xf
  // stop first: timing fields only change while stopped
  // run must be clear before the enable may change
  task automatic setup(input int m);
    xf(1, 12'h004, 0);
    xf(1, 12'h004, 0);
    xf(1, 12'h000, m);
  endtask : setup
  task automatic meas(output int t, output int c, output int s);
    t = 0;
    c = 0;
    s = 0;
    do begin
      @(posedge clock_in);
      c++;
      t += conv_tick_out;
      s += sampling_out;
    end while (conv_done_out !== 1'b1);
  endtask : meas
  task automatic t_regs;
    xf(0, 12'h000, 0);
    `CHK("mode", 32'h0, rd)
    xf(0, 12'h004, 0);
    `CHK("ctrl", 32'h4, rd)
    xf(0, 12'h00c, 0);
    `CHK("unmapped", 1'b1, er)
  endtask : t_regs
  task automatic t_refuse;
    setup(64);
    xf(1, 12'h004, 3);
    xf(0, 12'h004, 0);
    `CHK("run", 1'b0, rd[0])
    xf(1, 12'h000, 7);
    xf(0, 12'h000, 0);
    `CHK("locked", 32'h40, rd)
  endtask : t_refuse
  task automatic t_sw(input int dv, input int lv);
    int g = 0;
    int q = smp[lv] * rat[dv];
    setup(32 + lv * 8 + dv);
    xf(1, 12'h004, 2);
    xf(1, 12'h004, 3);
    meas(tk, cy, sp);
    meas(tk, cy, sp);
    `CHK("ticks8", n8[lv], tk)
    `CHK("samp8", 1'b1, sp >= q && sp <= q + 2)
    do @(posedge clock_in); while (conv_tick_out !== 1'b1);
    do begin
      @(posedge clock_in);
      g++;
    end while (conv_tick_out !== 1'b1);
    `CHK("gap", rat[dv], g)
  endtask : t_sw
  task automatic t_hw(input int dv, input int lv);
    int e = rat[dv] * n12[lv];
    int s = (dv == 7 && lv < 2) ? stb[lv] / 2 : stb[lv];
    int q = smp[lv] * rat[dv];
    setup(64 + lv * 8 + dv);
    xf(1, 12'h004, 2);
    fire <= 1;
    @(posedge clock_in) fire <= 0;
    meas(tk, cy, sp);
    `CHK("ticks12", n12[lv], tk)
    `CHK("samp12", 1'b1, sp >= q && sp <= q + 2)
    `CHK("first", 1'b1, cy >= e + s && cy <= e + s + 6)
    fire <= 1;
    @(posedge clock_in) fire <= 0;
    meas(tk, cy, sp);
    `CHK("later", 1'b1, cy >= e && cy <= e + 6)
    `CHK("later ticks", n12[lv], tk)
  endtask : t_hw
  initial begin
    repeat (12) @(posedge clock_in);
    rst_in <= 0;
    @(posedge clock_in);
    t_regs();
    t_refuse();
    // each ratio used is legal at some fclk; no high channel or
    // internal source is converted, so no mode is barred
    for (int l = 0; l < 4; l++) t_sw(7, l);
    t_sw(3, 0);
    for (int l = 0; l < 4; l++) t_hw(7, l);
    t_hw(0, 0);
    t_hw(5, 1);
    end_of_test();
  end
endmodule : conv_timing_select_tb_top

//--- test/trig_source.sv
// Purpose: hardware trigger source at the far side
// Assumes: one request gives one pulse
// Notes: registered, so the pulse lags by a cycle
`timescale 1ns/1ps
module trig_source (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic fire_in,
  output logic hw_trigger_out
);
  always_ff @(posedge clock_in) begin
    hw_trigger_out <= fire_in && !rst_in;
  end
endmodule : trig_source
